// ==== core/adrr_pkg.sv ====
// Constants for the converter result-data register bank.
// Assumes a 32-bit classic Wishbone slave with a 12-bit byte address.
// Operation
// (R1) Results are 16-bit, read-only to software.
// (R2) Eight unit-0 results, twenty-one unit-1 results.
// (R3) Extended control selects delivered result precision; only the 10-bit code delivers data, others read zero unless legacy is set.
// (R4) Extended control selects right or left alignment.
// (R5) 10-bit: align 0 bits 9:0, 1 bits 15:6.
// (R6) Legacy layout: 10-bit result in bits 15:6.
// (R7) Unused bits read zero; reset clears results.
package adrr_pkg;

  // ----------------------------------------------------------------
  // Bus and register map.
  // ----------------------------------------------------------------
  localparam int          ADR_W    = 12;
  localparam int          DAT_W    = 32;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] U0_OFF   = 12'h100;
  localparam logic [11:0] U1_OFF   = 12'h200;

  // ----------------------------------------------------------------
  // Result storage.
  // ----------------------------------------------------------------
  localparam int          RES_W    = 10;
  localparam int          REG_W    = 16;
  localparam int          IDX_W    = 5;
  localparam logic [4:0]  U0_DEPTH = 5'h08;
  localparam logic [4:0]  U1_DEPTH = 5'h15;
  localparam int          PAD_W    = REG_W - RES_W;

  // ----------------------------------------------------------------
  // Control extension fields and reset values.
  // ----------------------------------------------------------------
  localparam int          PREC_LSB   = 0;
  localparam int          PREC_W     = 2;
  localparam int          ALIGN_BIT  = 2;
  localparam int          LEGACY_BIT = 3;
  localparam logic [1:0]  PREC_10BIT = 2'h1;
  localparam logic [1:0]  PREC_RST   = 2'h1;
  localparam logic        ALIGN_RST  = 1'h0;
  localparam logic        LEGACY_RST = 1'h0;

  // ----------------------------------------------------------------
  // Status fields.
  // ----------------------------------------------------------------
  localparam int          STAT_IDX_LSB  = 0;
  localparam int          STAT_UNIT_BIT = 5;
  localparam int          STAT_SEEN_BIT = 6;

endpackage

// ==== core/adrr_fmt.sv ====
// Places one stored 10-bit result in the 16-bit result word.
// Assumes the precision, alignment and legacy controls are stable register outputs.
`timescale 1ns/1ps

module adrr_fmt (
  // Stored result.
  input  wire logic [9:0]  raw_i,
  // Layout controls.
  input  wire logic [1:0]  prec_i,
  input  wire logic        align_i,
  input  wire logic        legacy_i,
  // Formatted word.
  output logic      [15:0] word_o
);

  logic        is10_w;
  logic        left_w;
  logic [15:0] right_word_w;
  logic [15:0] left_word_w;

  // Legacy layout forces the left-aligned 10-bit placement. [R6]
  assign is10_w       = legacy_i | (prec_i == adrr_pkg::PREC_10BIT);
  assign left_w       = legacy_i | align_i;
  // Unoccupied bits are zero-filled. [R5] [R7]
  assign right_word_w = {{adrr_pkg::PAD_W{1'b0}}, raw_i};
  assign left_word_w  = {raw_i, {adrr_pkg::PAD_W{1'b0}}};
  // Only the 10-bit precision is carried; other codes deliver no data unless legacy layout is set. [R3] [R4]
  assign word_o       = !is10_w ? 16'h0000 : (left_w ? left_word_w : right_word_w);

endmodule

// ==== core/adrr_regs.sv ====
// Result-data register bank of a two-unit converter with a Wishbone slave.
// Assumes the converter core presents each finished result as a one-cycle strobe.
`timescale 1ns/1ps

module adrr_regs (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter result input.
  input  wire logic        conv_valid_i,
  input  wire logic        conv_unit_i,
  input  wire logic [4:0]  conv_index_i,
  input  wire logic [9:0]  conv_result_i,
  // Layout controls seen by the converter.
  output logic      [1:0]  result_precision_select_o,
  output logic             result_align_select_o,
  output logic             legacy_layout_o
);

  // ----------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------
  // True when the index exists in the given unit. [R2]
  function automatic logic res_ok(input logic unit, input logic [4:0] idx);
    res_ok = unit ? (idx < adrr_pkg::U1_DEPTH) : (idx < adrr_pkg::U0_DEPTH);
  endfunction

  // True when the address falls in the 128-byte window at base.
  function automatic logic in_block(input logic [11:0] adr, input logic [11:0] base);
    in_block = (adr[11:7] == base[11:7]);
  endfunction

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [7:0][9:0]  mem0_r;
  logic [20:0][9:0] mem1_r;
  logic             ack_r;
  logic [31:0]      dat_r;
  logic [1:0]       prec_r;
  logic             align_r;
  logic             legacy_r;
  logic [4:0]       last_idx_r;
  logic             last_unit_r;
  logic             seen_r;

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic        req_w;
  logic        wr_w;
  logic        rd_w;
  logic [4:0]  idx_w;
  logic        hit_ctrl_w;
  logic        hit_stat_w;
  logic        hit_u0_w;
  logic        hit_u1_w;
  logic        conv_ok_w;
  logic        ctrl_wr_w;
  logic [9:0]  raw_sel_w;
  logic [15:0] res_word_w;
  logic [31:0] ctrl_word_w;
  logic [31:0] stat_word_w;
  logic [31:0] rd_word_w;

  assign req_w      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_w       = req_w & wb_we_i;
  assign rd_w       = req_w & ~wb_we_i;
  assign idx_w      = wb_adr_i[6:2];
  assign hit_ctrl_w = (wb_adr_i[11:2] == adrr_pkg::CTRL_OFF[11:2]);
  assign hit_stat_w = (wb_adr_i[11:2] == adrr_pkg::STAT_OFF[11:2]);
  assign hit_u0_w   = in_block(wb_adr_i, adrr_pkg::U0_OFF) & res_ok(1'b0, idx_w);
  assign hit_u1_w   = in_block(wb_adr_i, adrr_pkg::U1_OFF) & res_ok(1'b1, idx_w);
  assign ctrl_wr_w  = wr_w & hit_ctrl_w & wb_sel_i[0];
  assign conv_ok_w  = conv_valid_i & res_ok(conv_unit_i, conv_index_i);

  // Result read selects the stored value; software writes never reach it. [R1]
  assign raw_sel_w  = hit_u0_w ? mem0_r[idx_w[2:0]] : (hit_u1_w ? mem1_r[idx_w] : 10'h000);

  adrr_fmt u_fmt (
    .raw_i    (raw_sel_w),
    .prec_i   (prec_r),
    .align_i  (align_r),
    .legacy_i (legacy_r),
    .word_o   (res_word_w)
  );

  always_comb begin
    ctrl_word_w = 32'h0000_0000;
    ctrl_word_w[adrr_pkg::PREC_LSB +: adrr_pkg::PREC_W] = prec_r;
    ctrl_word_w[adrr_pkg::ALIGN_BIT]                    = align_r;
    ctrl_word_w[adrr_pkg::LEGACY_BIT]                   = legacy_r;
  end

  always_comb begin
    stat_word_w = 32'h0000_0000;
    stat_word_w[adrr_pkg::STAT_IDX_LSB +: adrr_pkg::IDX_W] = last_idx_r;
    stat_word_w[adrr_pkg::STAT_UNIT_BIT]                    = last_unit_r;
    stat_word_w[adrr_pkg::STAT_SEEN_BIT]                    = seen_r;
  end

  // Upper half of a result word reads zero; unmapped addresses read zero. [R1] [R7]
  assign rd_word_w = hit_ctrl_w ? ctrl_word_w :
                     hit_stat_w ? stat_word_w :
                     (hit_u0_w | hit_u1_w) ? {16'h0000, res_word_w} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus answer.
  // ----------------------------------------------------------------
  // Every access, mapped or not, is acknowledged one cycle after it starts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_w;
      dat_r <= rd_w ? rd_word_w : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------------------------------
  // Control extension register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prec_r   <= adrr_pkg::PREC_RST;
      align_r  <= adrr_pkg::ALIGN_RST;
      legacy_r <= adrr_pkg::LEGACY_RST;
    end else if (ctrl_wr_w) begin
      prec_r   <= wb_dat_i[adrr_pkg::PREC_LSB +: adrr_pkg::PREC_W]; // [R3]
      align_r  <= wb_dat_i[adrr_pkg::ALIGN_BIT];                    // [R4]
      legacy_r <= wb_dat_i[adrr_pkg::LEGACY_BIT];                   // [R6]
    end
  end

  assign result_precision_select_o = prec_r;
  assign result_align_select_o     = align_r;
  assign legacy_layout_o           = legacy_r;

  // ----------------------------------------------------------------
  // Result storage.
  // ----------------------------------------------------------------
  // Only the converter strobe writes here; indices past a unit's depth are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem0_r <= '0; // [R7]
      mem1_r <= '0; // [R7]
    end else if (conv_ok_w) begin
      if (conv_unit_i) begin
        mem1_r[conv_index_i] <= conv_result_i; // [R2]
      end else begin
        mem0_r[conv_index_i[2:0]] <= conv_result_i; // [R2]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_idx_r  <= 5'h00;
      last_unit_r <= 1'b0;
      seen_r      <= 1'b0;
    end else if (conv_ok_w) begin
      last_idx_r  <= conv_index_i;
      last_unit_r <= conv_unit_i;
      seen_r      <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) // [R1]
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // [R1]
    else $error("ack not given one cycle after request");

  result_read_only_a: assert property (wr_w && (hit_u0_w || hit_u1_w) && !conv_valid_i // [R1]
                                       |=> $stable(mem0_r) && $stable(mem1_r))
    else $error("software write changed a result");

  unit0_depth_a: assert property (conv_valid_i && !conv_unit_i && conv_index_i >= 5'h08 // [R2]
                                  |=> $stable(mem0_r) && $stable(mem1_r))
    else $error("unit 0 accepted an index past seven");

  unit1_store_a: assert property (conv_valid_i && conv_unit_i && conv_index_i == 5'h14 // [R2]
                                  |=> mem1_r[20] == $past(conv_result_i))
    else $error("unit 1 index twenty not stored");

  prec_steer_a: assert property (rd_w && (hit_u0_w || hit_u1_w) && !legacy_r && prec_r != 2'h1 // [R3]
                                 |=> wb_dat_o == 32'h0000_0000)
    else $error("non 10-bit precision delivered data");

  right_align_a: assert property (rd_w && hit_u0_w && prec_r == 2'h1 && !align_r && !legacy_r // [R5]
                                  |=> wb_dat_o == {22'h000000, $past(mem0_r[idx_w[2:0]])})
    else $error("right aligned result misplaced");

  left_align_a: assert property (rd_w && hit_u1_w && prec_r == 2'h1 && align_r // [R4]
                                 |=> wb_dat_o == {16'h0000, $past(raw_sel_w), 6'h00})
    else $error("left aligned result misplaced");

  legacy_layout_a: assert property (rd_w && (hit_u0_w || hit_u1_w) && legacy_r // [R6]
                                    |=> wb_dat_o[15:6] == $past(raw_sel_w) && wb_dat_o[5:0] == 6'h00)
    else $error("legacy layout not left aligned");

  reset_clear_a: assert property ($fell(rst_i) |-> mem0_r == '0 && mem1_r == '0 && !seen_r) // [R7]
    else $error("results not cleared by reset");

  upper_zero_a: assert property (rd_w && (hit_u0_w || hit_u1_w) |=> wb_dat_o[31:16] == 16'h0000) // [R7]
    else $error("upper half of result word not zero");

  // ----------------------------------------------------------------
  // Bus, control, status and further result checks.
  // ----------------------------------------------------------------
  ack_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) // [R1]
    else $error("ack without a request");

  ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o) // [R1]
    else $error("ack given while the bus was idle");

  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) // [R7]
    else $error("read data not zero outside an ack");

  write_zero_a: assert property (wr_w |=> wb_dat_o == 32'h0000_0000) // [R1]
    else $error("write returned data");

  unmapped_zero_a: assert property (rd_w && !hit_ctrl_w && !hit_stat_w && !hit_u0_w && !hit_u1_w // [R7]
                                    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  ctrl_reset_a: assert property ($fell(rst_i) |-> prec_r == adrr_pkg::PREC_RST // [R3]
                                 && align_r == adrr_pkg::ALIGN_RST && legacy_r == adrr_pkg::LEGACY_RST)
    else $error("control not restored by reset");

  ctrl_write_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] // [R3]
                                 && wb_adr_i[11:2] == adrr_pkg::CTRL_OFF[11:2]
                                 |=> prec_r == $past(wb_dat_i[adrr_pkg::PREC_LSB +: adrr_pkg::PREC_W])
                                 && align_r == $past(wb_dat_i[adrr_pkg::ALIGN_BIT])
                                 && legacy_r == $past(wb_dat_i[adrr_pkg::LEGACY_BIT]))
    else $error("control write not taken");

  ctrl_hold_a: assert property (!ctrl_wr_w // [R3]
                                |=> $stable(prec_r) && $stable(align_r) && $stable(legacy_r))
    else $error("control changed without a write");

  sel_mask_a: assert property (wr_w && hit_ctrl_w && !wb_sel_i[0] // [R3]
                               |=> $stable(prec_r) && $stable(align_r) && $stable(legacy_r))
    else $error("control write without its byte lane took effect");

  ctrl_read_a: assert property (rd_w && hit_ctrl_w // [R3]
                                |=> wb_dat_o == {28'h0000000, $past(legacy_r), $past(align_r), $past(prec_r)})
    else $error("control readback wrong");

  right_unit1_a: assert property (rd_w && hit_u1_w && prec_r == 2'h1 && !align_r && !legacy_r // [R5]
                                  |=> wb_dat_o == {22'h000000, $past(mem1_r[idx_w])})
    else $error("unit 1 right aligned result misplaced");

  left_unit0_a: assert property (rd_w && hit_u0_w && prec_r == 2'h1 && align_r && !legacy_r // [R5]
                                 |=> wb_dat_o == {16'h0000, $past(mem0_r[idx_w[2:0]]), 6'h00})
    else $error("unit 0 left aligned result misplaced");

  unit0_store_a: assert property (conv_valid_i && !conv_unit_i && conv_index_i < 5'h08 // [R2]
                                  |=> mem0_r[$past(conv_index_i[2:0])] == $past(conv_result_i))
    else $error("unit 0 result not stored");

  unit1_range_a: assert property (conv_valid_i && conv_unit_i && conv_index_i > 5'h14 // [R2]
                                  |=> $stable(mem0_r) && $stable(mem1_r))
    else $error("unit 1 accepted an index past twenty");

  read_no_store_a: assert property (rd_w && !conv_valid_i // [R1]
                                    |=> $stable(mem0_r) && $stable(mem1_r))
    else $error("read changed a result");

  stat_read_a: assert property (rd_w && hit_stat_w // [R2]
                                |=> wb_dat_o == {25'h0, $past(seen_r), $past(last_unit_r), $past(last_idx_r)})
    else $error("status readback wrong");

  stat_update_a: assert property (conv_valid_i && res_ok(conv_unit_i, conv_index_i) // [R2]
                                  |=> last_idx_r == $past(conv_index_i)
                                  && last_unit_r == $past(conv_unit_i) && seen_r)
    else $error("status not updated by a stored result");

  stat_hold_a: assert property (!(conv_valid_i && res_ok(conv_unit_i, conv_index_i)) // [R2]
                                |=> $stable(last_idx_r) && $stable(last_unit_r) && $stable(seen_r))
    else $error("status changed without a stored result");

  stat_ro_a: assert property (wr_w && hit_stat_w && !conv_valid_i // [R2]
                              |=> $stable(last_idx_r) && $stable(seen_r))
    else $error("software write changed the status");

  seen_sticky_a: assert property (seen_r |=> seen_r) // [R2]
    else $error("stored flag dropped without reset");

  fresh_clear_a: assert property (!seen_r // [R7]
                                  |-> mem0_r == '0 && mem1_r == '0)
    else $error("result nonzero before any store");

endmodule

// ==== sim/adrr_regs_test.sv ====
// Self-checking bench for the converter result register bank.
// Assumes the design package and adrr_regs are compiled first; clock is 25 MHz.
`timescale 1ns/1ps

module adrr_regs_test;
  // ----------------------------------------------------------------
  // Stimulus, observation and model state.
  // ----------------------------------------------------------------
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        wb_cyc_i      = 1'b0;
  logic        wb_stb_i      = 1'b0;
  logic        wb_we_i       = 1'b0;
  logic [11:0] wb_adr_i      = 12'h000;
  logic [3:0]  wb_sel_i      = 4'h0;
  logic [31:0] wb_dat_i      = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        conv_valid_i  = 1'b0;
  logic        conv_unit_i   = 1'b0;
  logic [4:0]  conv_index_i  = 5'h00;
  logic [9:0]  conv_result_i = 10'h000;
  logic [1:0]  prec_o;
  logic        align_o;
  logic        legacy_o;
  integer      seed          = 32'h3af0e45e;
  integer      err_total     = 0;
  integer      comparisons   = 0;
  logic [9:0]  u0_m [8];
  logic [9:0]  u1_m [21];
  logic [31:0] q;
  logic [31:0] r;
  logic [3:0]  sel_m         = 4'hf;

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  adrr_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_valid_i(conv_valid_i), .conv_unit_i(conv_unit_i), .conv_index_i(conv_index_i),
    .conv_result_i(conv_result_i), .result_precision_select_o(prec_o), .result_align_select_o(align_o),
    .legacy_layout_o(legacy_o)
  );

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; holds the request until ack is seen at a rising edge.
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat, output logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel_m;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("ack", {31'h0, wb_ack_o}, 32'h1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic conv(input logic unit, input logic [4:0] idx, input logic [9:0] val);
    conv_valid_i  <= 1'b1;
    conv_unit_i   <= unit;
    conv_index_i  <= idx;
    conv_result_i <= val;
    @(posedge clk_i);
    if (!unit && idx < 5'h08) u0_m[idx[2:0]] = val;
    if (unit && idx < 5'h15) u1_m[idx] = val;
  endtask

  function automatic logic [31:0] fmt(input logic [9:0] raw, input logic [1:0] p, input logic a, input logic l);
    if (l || (p == 2'h1 && a)) return {16'h0, raw, 6'h00};
    if (p == 2'h1) return {22'h0, raw};
    return 32'h0;
  endfunction

  function automatic logic [31:0] stat_exp(input logic [4:0] idx, input logic unit, input logic seen);
    return (32'(idx) << adrr_pkg::STAT_IDX_LSB) | (32'(unit) << adrr_pkg::STAT_UNIT_BIT)
           | (32'(seen) << adrr_pkg::STAT_SEEN_BIT);
  endfunction

  task automatic check_all(input logic [1:0] p, input logic a, input logic l);
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, adrr_pkg::U0_OFF + 12'(i * 4), 32'h0, d);
      chk("unit0 result", d, fmt(u0_m[i], p, a, l));
    end
    for (int i = 0; i < 21; i++) begin
      wb(1'b0, adrr_pkg::U1_OFF + 12'(i * 4), 32'h0, d);
      chk("unit1 result", d, fmt(u1_m[i], p, a, l));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end

  initial begin
    foreach (u0_m[i]) u0_m[i] = 10'h000;
    foreach (u1_m[i]) u1_m[i] = 10'h000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, adrr_pkg::CTRL_OFF, 32'h0, q);
    chk("control reset", q, 32'h1);
    wb(1'b0, adrr_pkg::STAT_OFF, 32'h0, q);
    chk("status reset", q, stat_exp(5'h00, 1'b0, 1'b0));
    check_all(2'h1, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) conv(1'b0, 5'(i), 10'($random(seed)));
    for (int i = 0; i < 21; i++) conv(1'b1, 5'(i), 10'($random(seed)));
    conv(1'b0, 5'h00, 10'h3ff);
    conv(1'b1, 5'h14, 10'h001);
    conv(1'b0, 5'h08, 10'h155);
    conv(1'b1, 5'h15, 10'h2aa);
    conv(1'b1, 5'h1f, 10'h3ff);
    conv_valid_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, adrr_pkg::STAT_OFF, 32'h0, q);
    chk("status after stores", q, stat_exp(5'h14, 1'b1, 1'b1));
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      wb(1'b1, adrr_pkg::CTRL_OFF, {r[31:4], 4'(c)}, q);
      chk("layout outputs", {28'h0, legacy_o, align_o, prec_o}, 32'(c));
      wb(1'b0, adrr_pkg::CTRL_OFF, 32'h0, q);
      chk("control readback", q, 32'(c));
      check_all(2'(c), c[2], c[3]);
    end
    r = $random(seed);
    wb(1'b1, adrr_pkg::U0_OFF + 12'h00c, r, q);
    wb(1'b1, adrr_pkg::U1_OFF + 12'h050, ~r, q);
    wb(1'b1, 12'h300, r, q);
    wb(1'b1, adrr_pkg::STAT_OFF, r, q);
    wb(1'b0, 12'h300, 32'h0, q);
    chk("unmapped read", q, 32'h0);
    wb(1'b0, adrr_pkg::STAT_OFF, 32'h0, q);
    chk("status after writes", q, stat_exp(5'h14, 1'b1, 1'b1));
    wb(1'b1, adrr_pkg::CTRL_OFF, 32'h5, q);
    sel_m = 4'he;
    wb(1'b1, adrr_pkg::CTRL_OFF, 32'ha, q);
    sel_m = 4'hf;
    wb(1'b0, adrr_pkg::CTRL_OFF, 32'h0, q);
    chk("control lane masked", q, 32'h5);
    check_all(2'h1, 1'b1, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (u0_m[i]) u0_m[i] = 10'h000;
    foreach (u1_m[i]) u1_m[i] = 10'h000;
    wb(1'b0, adrr_pkg::CTRL_OFF, 32'h0, q);
    chk("control after reset", q, 32'h1);
    wb(1'b0, adrr_pkg::STAT_OFF, 32'h0, q);
    chk("status after reset", q, stat_exp(5'h00, 1'b0, 1'b0));
    check_all(2'h1, 1'b0, 1'b0);
    finish_test();
  end
endmodule
